// ---- verilog/csr_pkg.sv ----
// constants shared by the special register block
package csr_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] CSR_OFF_BANK = 4'h0;
	localparam logic [3:0] CSR_OFF_PCL = 4'h1;
	localparam logic [3:0] CSR_OFF_TABLE_POINTER_LOW = 4'h2;
	localparam logic [3:0] CSR_OFF_TABLE_POINTER_HIGH = 4'h3;
	localparam logic [3:0] CSR_OFF_TBRES = 4'h4;
	localparam logic [3:0] CSR_OFF_ACC = 4'h5;
	localparam logic [3:0] CSR_OFF_FLAGS = 4'h6;
	localparam logic [3:0] CSR_OFF_PCHI = 4'h7;
	localparam logic [3:0] CSR_OFF_DBANK = 4'h8;
	// bank selector fields
	localparam int CSR_BANK_PROG_BIT = 5;
	localparam logic [7:0] CSR_BANK_MASK_SMALL = 8'h01;
	localparam logic [7:0] CSR_BANK_MASK_MEDIUM = 8'h03;
	localparam logic [7:0] CSR_BANK_MASK_LARGE = 8'h27;
	localparam logic [7:0] CSR_BANK_RST = 8'h00;
	// flag register fields
	localparam int CSR_FLAG_C = 0;
	localparam int CSR_FLAG_AC = 1;
	localparam int CSR_FLAG_Z = 2;
	localparam int CSR_FLAG_OV = 3;
	localparam int CSR_FLAG_PDF = 4;
	localparam int CSR_FLAG_TO = 5;
	localparam logic [7:0] CSR_FLAG_RST = 8'h00;
	localparam logic [7:0] CSR_FLAG_SW_MASK = 8'h0F;
	// program address layout: 13 bits per program bank
	localparam int CSR_PROG_AW = 14;
	localparam logic [7:0] CSR_BYTE_RST = 8'h00;
	// alu operation codes
	typedef enum logic [2:0] {
		CSR_OP_NONE, CSR_OP_ADD, CSR_OP_SUB, CSR_OP_AND,
		CSR_OP_OR, CSR_OP_XOR, CSR_OP_RLC, CSR_OP_RRC
	} csr_op_type;
	// bank selector size variants
	localparam int CSR_VAR_SMALL = 0;
	localparam int CSR_VAR_MEDIUM = 1;
	localparam int CSR_VAR_LARGE = 2;
endpackage : csr_pkg

// ---- verilog/csr_alu.sv ----
// arithmetic unit producing a result and its status flags
`timescale 1ns/1ps
module csr_alu
	import csr_pkg::*;
(
	// operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	input wire csr_op_type op,
	// results
	output logic [7:0] res,
	output logic c_out,
	output logic ac_out,
	output logic ov_out,
	output logic z_out,
	output logic arith,
	output logic rot
);
	logic [8:0] sum; // nine bits keep the carry out
	logic [4:0] nib; // low nibble with its carry
	logic [7:0] bb; // second operand, inverted for subtract
	logic cin; // carry into bit 0
	logic c7; // carry into the top bit

	// one adder serves add and subtract; subtract is a + ~b + 1
	always_comb begin
		bb = (op == CSR_OP_SUB) ? ~b : b;
		cin = (op == CSR_OP_SUB);
		sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		c7 = a[7] ^ bb[7] ^ sum[7];
		res = 8'h00;
		c_out = c_in;
		arith = 1'b0;
		rot = 1'b0;
		case (op)
			CSR_OP_ADD, CSR_OP_SUB: begin
				// carry set means no borrow on subtract
				res = sum[7:0];
				c_out = sum[8];
				arith = 1'b1;
			end
			CSR_OP_AND: res = a & b;
			CSR_OP_OR: res = a | b;
			CSR_OP_XOR: res = a ^ b;
			CSR_OP_RLC: begin
				res = {a[6:0], c_in};
				c_out = a[7];
				rot = 1'b1;
			end
			CSR_OP_RRC: begin
				res = {c_in, a[7:1]};
				c_out = a[0];
				rot = 1'b1;
			end
			default: res = a;
		endcase
		ac_out = nib[4];
		ov_out = c7 ^ sum[8];
		z_out = (res == 8'h00);
	end
endmodule : csr_alu

// ---- verilog/csr_special_regs.sv ----
// special function registers of the small 8-bit core
// What this block does
// - small variant: bank bit 0, reset 0
// - medium variant: two-bit data bank field
// - large variant: bit 5 selects program bank
// - large variant: three-bit data bank field
// - unimplemented bits read as zero
// - pc low write jumps in page, dummy cycle
// - table read: high byte to result register
// - register moves pass only through accumulator
// - flag writes leave timeout and power-down alone
// - timeout flag: cleared by clear/halt, set timeout
// - power-down flag: cleared by clear, set halt
// - carry from add, no-borrow, or rotate
// - half carry from low nibble
// - zero flag on zero result
// - overflow when carry in differs carry out
// - flags not saved on interrupt or call
// - direct addressing always reaches bank 0
// - reset zeroes data bank except timeout halt
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module csr_special_regs
	import csr_pkg::*;
#(
	parameter int VARIANT = CSR_VAR_LARGE
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// core events
	input wire logic watchdog_clear_instr,
	input wire logic halt_instr,
	input wire logic wdt_timeout,
	input wire logic wdt_reset_in_pd,
	input wire logic soft_reset,
	input wire logic call_or_irq,
	// alu request
	input wire logic alu_go,
	input wire csr_op_type alu_op,
	input wire logic [7:0] alu_operand,
	// table read request and program word
	input wire logic tbl_go,
	input wire logic [15:0] prog_word,
	// data memory address request
	input wire logic dm_direct,
	// outputs to the core
	output logic [7:0] bank_selector,
	output logic [2:0] dm_bank,
	output logic [CSR_PROG_AW-1:0] pc_jump_addr,
	output logic pc_jump,
	output logic dummy_cycle,
	output logic [CSR_PROG_AW-1:0] tbl_addr,
	output logic [7:0] tbl_low_data,
	output logic tbl_low_valid,
	output logic [7:0] accumulator_reg,
	output logic [7:0] core_flags
);
	// mask of implemented bank selector bits for this variant
	// small keeps bit 0, medium bits 1..0, large bits 5 and 2..0
	// one mask shared by the write path and the read mux, so a
	// variant change cannot leave the two out of step
	localparam logic [7:0] BANK_MASK = (VARIANT == CSR_VAR_SMALL) ?
		CSR_BANK_MASK_SMALL : (VARIANT == CSR_VAR_MEDIUM) ?
		CSR_BANK_MASK_MEDIUM : CSR_BANK_MASK_LARGE;

	logic [7:0] bank_r; // bank selector, unimplemented bits zero
	logic [7:0] pcl_r; // pc low byte
	logic [5:0] pch_r; // pc high bits within program bank
	logic [7:0] table_pointer_low_r; // table pointer low
	logic [7:0] table_pointer_high_r; // table pointer high
	logic [7:0] tbres_r; // table result high byte
	logic [7:0] acc_r; // accumulator
	logic [3:0] arf_r; // arithmetic flags: ov, z, ac, c
	logic to_r; // watchdog timeout flag
	logic pdf_r; // power-down flag
	logic [5:0] flags_r; // flag bits 5..0 gathered for reads
	logic [7:0] rdata_r; // read data register
	logic jump_r; // jump strobe
	logic dummy_r; // dummy cycle strobe
	logic tlv_r; // table low byte strobe
	logic [7:0] tld_r; // table low byte
	logic [2:0] dmb_r; // data bank for the current access
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_ac;
	logic alu_ov;
	logic alu_z;
	logic alu_arith;
	logic alu_rot;
	logic wr_bank;
	logic wr_flags;
	logic [7:0] bank_nxt;
	logic [7:0] rdata_nxt;

	// arithmetic unit works on accumulator and operand
	csr_alu u_alu (
		.a(acc_r),
		.b(alu_operand),
		.c_in(flags_r[CSR_FLAG_C]),
		.op(alu_op),
		.res(alu_res),
		.c_out(alu_c),
		.ac_out(alu_ac),
		.ov_out(alu_ov),
		.z_out(alu_z),
		.arith(alu_arith),
		.rot(alu_rot)
	);

	assign wr_bank = reg_wr && (reg_addr == CSR_OFF_BANK);
	assign wr_flags = reg_wr && (reg_addr == CSR_OFF_FLAGS);
	assign bank_nxt = reg_wdata & BANK_MASK;
	// timeout and power-down each have a process, the four arithmetic flags share one; gather them here
	assign flags_r = {to_r, pdf_r, arf_r};
	assign reg_rdata = rdata_r; // straight from the read flop

	// bank selector; a timeout wake from halt keeps the data bank
	// soft reset outranks a write in the same cycle, as a reset
	// must leave the core in a known bank whatever software did
	// the program bank bit clears together with the data bank
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bank_r <= CSR_BANK_RST;
		end else if (soft_reset) begin
			if (!wdt_reset_in_pd) begin
				bank_r <= CSR_BANK_RST;
			end
		end else if (wr_bank) begin
			bank_r <= bank_nxt;
		end
	end

	// data bank seen by memory: direct access always bank 0
	// registered so the memory sees a clean bank with the address;
	// costs one cycle of latency after a bank change
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dmb_r <= 3'h0;
		end else if (dm_direct) begin
			dmb_r <= 3'h0;
		end else begin
			dmb_r <= bank_r[2:0];
		end
	end

	// pc low write jumps inside current page; high bits stay
	// only eight bits are writable, so a jump cannot leave the page
	// the high bits come from their own offset, written beforehand
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pcl_r <= CSR_BYTE_RST;
			pch_r <= 6'h00;
			jump_r <= 1'b0;
			dummy_r <= 1'b0;
		end else begin
			jump_r <= 1'b0;
			// dummy cycle follows the jump by one clock
			dummy_r <= jump_r;
			if (reg_wr && reg_addr == CSR_OFF_PCL) begin
				pcl_r <= reg_wdata;
				jump_r <= 1'b1;
			end
			if (reg_wr && reg_addr == CSR_OFF_PCHI) begin
				pch_r <= reg_wdata[5:0];
			end
		end
	end

	// table pointers written by software before any table read
	// no check that they were loaded: stale pointers read stale data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer_low_r <= CSR_BYTE_RST;
			table_pointer_high_r <= CSR_BYTE_RST;
		end else if (reg_wr) begin
			if (reg_addr == CSR_OFF_TABLE_POINTER_LOW) begin
				table_pointer_low_r <= reg_wdata;
			end
			if (reg_addr == CSR_OFF_TABLE_POINTER_HIGH) begin
				table_pointer_high_r <= reg_wdata;
			end
		end
	end

	// table read splits the program word into two bytes
	// the low byte leaves as a one-cycle strobe for the data path;
	// the high byte stays in the result register until the next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tbres_r <= CSR_BYTE_RST;
			tld_r <= CSR_BYTE_RST;
			tlv_r <= 1'b0;
		end else begin
			tlv_r <= tbl_go;
			if (tbl_go) begin
				tbres_r <= prog_word[15:8];
				tld_r <= prog_word[7:0];
			end
		end
	end

	// accumulator: the only path between user registers
	// there is no register-to-register move port at all, so a
	// transfer always takes two steps through this register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= CSR_BYTE_RST;
		end else if (alu_go && alu_op != CSR_OP_NONE) begin
			acc_r <= alu_res;
		end else if (reg_wr && reg_addr == CSR_OFF_ACC) begin
			acc_r <= reg_wdata;
		end
	end

	// arithmetic flags: alu result wins over a software write
	// a software write in the same cycle as an alu op is lost;
	// the core never issues both, so no merge logic is spent here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// true power-up state is unknown; zero keeps sims clean
			arf_r <= CSR_FLAG_RST[3:0];
		end else if (alu_go && alu_op != CSR_OP_NONE) begin
			// every alu op updates the zero flag
			arf_r[CSR_FLAG_Z] <= alu_z;
			// carry: add, subtract and both rotates
			if (alu_arith || alu_rot) begin
				arf_r[CSR_FLAG_C] <= alu_c;
			end
			// half carry and overflow: add and subtract only
			if (alu_arith) begin
				arf_r[CSR_FLAG_AC] <= alu_ac;
				arf_r[CSR_FLAG_OV] <= alu_ov;
			end
		end else if (wr_flags) begin
			// only the four arithmetic bits take software data
			arf_r <= reg_wdata[3:0] & CSR_FLAG_SW_MASK[3:0];
		end
	end

	// timeout flag: hardware only, set wins over clear
	// a timeout racing a clear must not be lost, or the reset
	// cause would be misread after wake-up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			to_r <= 1'b0;
		end else if (wdt_timeout) begin
			to_r <= 1'b1;
		end else if (watchdog_clear_instr || halt_instr) begin
			// software writes never reach this flag
			to_r <= 1'b0;
		end
	end

	// power-down flag: halt sets, watchdog clear clears
	// halt outranks a clear in the same cycle, as the core
	// is about to sleep and the flag must say so
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pdf_r <= 1'b0;
		end else if (halt_instr) begin
			pdf_r <= 1'b1;
		end else if (watchdog_clear_instr) begin
			// software writes never reach this flag
			pdf_r <= 1'b0;
		end
	end
	// call_or_irq deliberately touches no flag: no automatic save
	// handlers that disturb the flags must store them themselves

	// read mux; unimplemented bits come back zero
	always_comb begin
		case (reg_addr)
			CSR_OFF_BANK: rdata_nxt = bank_r & BANK_MASK;
			CSR_OFF_PCL: rdata_nxt = pcl_r;
			CSR_OFF_TABLE_POINTER_LOW: rdata_nxt = table_pointer_low_r;
			CSR_OFF_TABLE_POINTER_HIGH: rdata_nxt = table_pointer_high_r;
			CSR_OFF_TBRES: rdata_nxt = tbres_r;
			CSR_OFF_ACC: rdata_nxt = acc_r;
			CSR_OFF_FLAGS: rdata_nxt = {2'b00, flags_r};
			CSR_OFF_PCHI: rdata_nxt = {2'b00, pch_r};
			CSR_OFF_DBANK: rdata_nxt = {5'h00, dmb_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	// read data held for exactly the cycle after the strobe
	// zero outside the slot, so a wired-or bus stays clean
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bank_selector <= CSR_BANK_RST;
			dm_bank <= 3'h0;
			pc_jump_addr <= '0;
			pc_jump <= 1'b0;
			dummy_cycle <= 1'b0;
			tbl_addr <= '0;
			tbl_low_data <= 8'h00;
			tbl_low_valid <= 1'b0;
			accumulator_reg <= 8'h00;
			core_flags <= CSR_FLAG_RST;
		end else begin
			bank_selector <= bank_r;
			dm_bank <= dmb_r;
			pc_jump_addr <= {bank_r[CSR_BANK_PROG_BIT] &
				(VARIANT == CSR_VAR_LARGE), pch_r[4:0], pcl_r};
			pc_jump <= jump_r;
			dummy_cycle <= dummy_r;
			tbl_addr <= {table_pointer_high_r[5:0], table_pointer_low_r};
			tbl_low_data <= tld_r;
			tbl_low_valid <= tlv_r;
			accumulator_reg <= acc_r;
			core_flags <= {2'b00, flags_r};
		end
	end
endmodule : csr_special_regs

// ---- bench/csr_chk_monitor.sv ----
// port relation checks for the special register block
`timescale 1ns/1ps
module csr_chk
	import csr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// events and requests
	input wire logic watchdog_clear_instr,
	input wire logic halt_instr,
	input wire logic wdt_timeout,
	input wire logic soft_reset,
	input wire logic tbl_go,
	input wire logic [15:0] prog_word,
	input wire logic dm_direct,
	// outputs watched
	input wire logic [7:0] bank_selector,
	input wire logic [2:0] dm_bank,
	input wire logic [CSR_PROG_AW-1:0] pc_jump_addr,
	input wire logic pc_jump,
	input wire logic dummy_cycle,
	input wire logic [7:0] tbl_low_data,
	input wire logic tbl_low_valid,
	input wire logic [7:0] core_flags
);
	logic [7:0] pw_lo; // low program byte, so $past sees a plain signal
	assign pw_lo = prog_word[7:0];
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read slot");
	property p_holes;
		(bank_selector & 8'hD8) == 8'h00 && core_flags[7:6] == 2'b00;
	endproperty
	a_holes: assert property (p_holes)
		else $error("unimplemented bit reads one");
	property p_bank_wr;
		reg_wr && reg_addr == CSR_OFF_BANK && !soft_reset |-> ##2
		bank_selector == ($past(reg_wdata, 2) & CSR_BANK_MASK_LARGE);
	endproperty
	a_bank_wr: assert property (p_bank_wr)
		else $error("bank selector write not masked");
	property p_pcl;
		reg_wr && reg_addr == CSR_OFF_PCL |-> ##2 pc_jump &&
		pc_jump_addr[7:0] == $past(reg_wdata, 2) ##1 dummy_cycle;
	endproperty
	a_pcl: assert property (p_pcl)
		else $error("pc low write gave no jump or dummy cycle");
	property p_tbl;
		tbl_go |-> ##2 tbl_low_valid && tbl_low_data == $past(pw_lo, 2);
	endproperty
	a_tbl: assert property (p_tbl)
		else $error("table low byte wrong");
	property p_halt;
		halt_instr && !wdt_timeout |-> ##2 core_flags[5:4] == 2'b01;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not set power-down and clear timeout");
	property p_clear;
		watchdog_clear_instr && !halt_instr && !wdt_timeout |-> ##2
		core_flags[5:4] == 2'b00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not zero timeout and power-down");
	property p_wdt;
		wdt_timeout && !halt_instr |-> ##2 core_flags[CSR_FLAG_TO];
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("timeout flag not set");
	property p_pdf_src;
		$rose(core_flags[CSR_FLAG_PDF]) |-> $past(halt_instr, 2);
	endproperty
	a_pdf_src: assert property (p_pdf_src)
		else $error("power-down flag set without halt");
	property p_direct;
		dm_direct[*3] |-> dm_bank == 3'h0;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct access left bank 0");
	c_jump: cover property (pc_jump);
	c_tbl: cover property (tbl_low_valid);
	c_pdf: cover property (core_flags[CSR_FLAG_PDF]);
endmodule : csr_chk

// ---- bench/csr_special_regs_tb_top.sv ----
// self-checking bench for the special register block
`timescale 1ns/1ps
module csr_special_regs_tb_top
	import csr_pkg::*;
;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
	// stimulus
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] ev = 4'h0; // clear, halt, timeout, soft reset
	logic in_pd = 1'b0;
	logic irq = 1'b0;
	logic alu_go = 1'b0;
	csr_op_type alu_op = CSR_OP_NONE;
	logic [7:0] alu_operand = 8'h00;
	logic tbl_go = 1'b0;
	logic [15:0] prog_word = 16'h0000;
	logic dm_direct = 1'b0;
	// observed
	logic [7:0] reg_rdata, bank_selector, tbl_low_data, accumulator_reg;
	logic [7:0] core_flags;
	logic [2:0] dm_bank;
	logic [CSR_PROG_AW-1:0] pc_jump_addr, tbl_addr;
	logic pc_jump, dummy_cycle, tbl_low_valid;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	csr_special_regs i_csr_special_regs (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .watchdog_clear_instr(ev[3]),
		.halt_instr(ev[2]), .wdt_timeout(ev[1]), .soft_reset(ev[0]),
		.wdt_reset_in_pd(in_pd), .call_or_irq(irq), .alu_go(alu_go),
		.alu_op(alu_op), .alu_operand(alu_operand), .tbl_go(tbl_go),
		.prog_word(prog_word), .dm_direct(dm_direct),
		.bank_selector(bank_selector), .dm_bank(dm_bank),
		.pc_jump_addr(pc_jump_addr), .pc_jump(pc_jump),
		.dummy_cycle(dummy_cycle), .tbl_addr(tbl_addr),
		.tbl_low_data(tbl_low_data), .tbl_low_valid(tbl_low_valid),
		.accumulator_reg(accumulator_reg), .core_flags(core_flags)
	);
	always #12.5 clk_sys = ~clk_sys;
	// hang guard; the run needs under two hundred cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	// let n edges pass, then look just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// data is valid only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd
	task automatic pulse(input logic [3:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= 4'h0;
	endtask : pulse
	// reset values and an unmapped offset
	task automatic t_reset;
		`CHK(bank_selector, CSR_BANK_RST)
		`CHK(core_flags, CSR_FLAG_RST)
		rd(CSR_OFF_BANK, 8'h00);
		rd(4'hF, 8'h00);
	endtask : t_reset
	// field mask, all data bank codes, direct access override
	task automatic t_bank;
		wr(CSR_OFF_BANK, 8'hFF);
		rd(CSR_OFF_BANK, 8'h27);
		tick(2);
		`CHK(bank_selector, 8'h27)
		for (int i = 0; i < 8; i++) begin
			wr(CSR_OFF_BANK, 8'(i));
			tick(3);
			`CHK(dm_bank, 3'(i))
		end
		@(posedge clk_sys);
		dm_direct <= 1'b1;
		tick(4);
		`CHK(dm_bank, 3'h0)
		@(posedge clk_sys);
		dm_direct <= 1'b0;
	endtask : t_bank
	// bank kept only for a timeout reset in power-down
	task automatic t_soft;
		wr(CSR_OFF_BANK, 8'h05);
		in_pd <= 1'b1;
		pulse(4'h1);
		tick(2);
		`CHK(bank_selector, 8'h05)
		@(posedge clk_sys);
		in_pd <= 1'b0;
		pulse(4'h1);
		tick(2);
		`CHK(bank_selector, 8'h00)
	endtask : t_soft
	// write mask, then halt, timeout, halt again and clear
	task automatic t_flags;
		wr(CSR_OFF_FLAGS, 8'hFF);
		rd(CSR_OFF_FLAGS, 8'h0F);
		pulse(4'h4);
		rd(CSR_OFF_FLAGS, 8'h1F);
		pulse(4'h2);
		rd(CSR_OFF_FLAGS, 8'h3F);
		pulse(4'h4);
		rd(CSR_OFF_FLAGS, 8'h1F);
		pulse(4'h8);
		rd(CSR_OFF_FLAGS, 8'h0F);
		wr(CSR_OFF_FLAGS, 8'h00);
		rd(CSR_OFF_FLAGS, 8'h00);
	endtask : t_flags
	// chained ops: {op, operand, acc after, flags after}
	task automatic t_alu;
		logic [31:0] tab [9] = '{32'h0101_800A, 32'h0280_0007,
			32'h0201_FF00, 32'h0101_0007, 32'h0555_5503, 32'h040A_5F03,
			32'h0600_BF02, 32'h0700_5F03, 32'h0300_0007};
		wr(CSR_OFF_ACC, 8'h7F);
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_sys);
			alu_op <= csr_op_type'(tab[i][26:24]);
			alu_operand <= tab[i][23:16];
			alu_go <= 1'b1;
			@(posedge clk_sys);
			alu_go <= 1'b0;
			rd(CSR_OFF_ACC, tab[i][15:8]);
			rd(CSR_OFF_FLAGS, tab[i][7:0]);
		end
	endtask : t_alu
	// pc low jump, table read, read-only result, call keeps flags
	task automatic t_misc;
		wr(CSR_OFF_PCL, 8'h5A);
		tick(2);
		`CHK(pc_jump_addr[7:0], 8'h5A)
		wr(CSR_OFF_TABLE_POINTER_LOW, 8'h34);
		wr(CSR_OFF_TABLE_POINTER_HIGH, 8'h12);
		@(posedge clk_sys);
		prog_word <= 16'hA55A;
		tbl_go <= 1'b1;
		@(posedge clk_sys);
		tbl_go <= 1'b0;
		wr(CSR_OFF_TBRES, 8'h00);
		rd(CSR_OFF_TBRES, 8'hA5);
		`CHK(tbl_low_data, 8'h5A)
		`CHK(tbl_addr, 14'h1234)
		`CHK(accumulator_reg, 8'h00)
		@(posedge clk_sys);
		irq <= 1'b1;
		tick(2);
		@(posedge clk_sys);
		irq <= 1'b0;
		rd(CSR_OFF_FLAGS, 8'h07);
	endtask : t_misc
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		tick(1);
		t_reset();
		t_bank();
		t_soft();
		t_flags();
		t_alu();
		t_misc();
		end_sim();
	end
endmodule : csr_special_regs_tb_top
bind csr_special_regs csr_chk i_csr_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .watchdog_clear_instr(watchdog_clear_instr),
	.halt_instr(halt_instr), .wdt_timeout(wdt_timeout),
	.soft_reset(soft_reset), .tbl_go(tbl_go), .prog_word(prog_word),
	.dm_direct(dm_direct), .bank_selector(bank_selector),
	.dm_bank(dm_bank), .pc_jump_addr(pc_jump_addr), .pc_jump(pc_jump),
	.dummy_cycle(dummy_cycle), .tbl_low_data(tbl_low_data),
	.tbl_low_valid(tbl_low_valid), .core_flags(core_flags)
);
